/* File: design/pwm_time_base_map.vh */
/*
 * Register offsets, field positions, reset values and encodings of the PWM time base.
 * Assumes a plain address/strobe register port with word-wide registers.
 */
`ifndef PWM_TIME_BASE_MAP_VH
`define PWM_TIME_BASE_MAP_VH

// Register offsets (word index on the register port)
`define ADDR_CONTROL        4'h0
`define ADDR_COUNT          4'h1
`define ADDR_PERIOD         4'h2
`define ADDR_IRQ_STATUS     4'h3
`define ADDR_IRQ_MASK       4'h4

// Control register fields
`define CTL_ENABLE_BIT      15
`define CTL_POST_LSB        4
`define CTL_POST_MSB        7
`define CTL_PRE_LSB         2
`define CTL_PRE_MSB         3
`define CTL_MODE_LSB        0
`define CTL_MODE_MSB        1

// Count register: direction flag position
`define CNT_DIR_BIT         15

// Interrupt status / mask bits
`define IRQ_TB_BIT          0
`define IRQ_WIDTH           1

// Mode encodings
`define MODE_FREE           2'h0
`define MODE_SINGLE         2'h1
`define MODE_UPDOWN         2'h2
`define MODE_DOUBLE         2'h3

// Prescale encodings and terminal counts (ratio minus one)
`define PRE_DIV1            2'h0
`define PRE_DIV4            2'h1
`define PRE_DIV16           2'h2
`define PRE_DIV64           2'h3
`define PRE_TC1             6'h00
`define PRE_TC4             6'h03
`define PRE_TC16            6'h0F
`define PRE_TC64            6'h3F

// Instruction clock is the input clock divided by four
`define INSN_DIV_TC         2'h3

// Reset values
`define RST_CONTROL         16'h0000
`define RST_COUNT           15'h0000
`define RST_PERIOD          15'h0000
`define RST_MASK            1'h0

`endif

/* File: design/tb_tick_gen.v */
/*
 * Tick generator: instruction clock divider followed by the selectable prescaler.
 * Assumes clk is the oscillator clock and clr is a one-cycle clear from register writes.
 */
`include "pwm_time_base_map.vh"
`default_nettype none

module tb_tick_gen (
    input  wire       clk,       // Oscillator clock
    input  wire       rstn,      // Synchronous reset, active low
    input  wire       clr,       // Clear prescale count
    input  wire [1:0] pre_sel,   // Prescale select
    output reg        tick       // One-cycle counting tick
);

    reg  [1:0] insn_reg;
    reg  [5:0] pre_reg;
    wire       insn_tick;
    reg  [5:0] pre_tc;

    // Terminal count of the prescaler from its select
    always @* begin
        case (pre_sel)
            `PRE_DIV1:  pre_tc = `PRE_TC1;
            `PRE_DIV4:  pre_tc = `PRE_TC4;
            `PRE_DIV16: pre_tc = `PRE_TC16;
            default:    pre_tc = `PRE_TC64;
        endcase
    end

    assign insn_tick = (insn_reg == `INSN_DIV_TC);

    // Oscillator/4 then prescale; prescale count cleared by writes, both counts by reset
    always @(posedge clk) begin
        if (!rstn) begin
            insn_reg <= 2'h0;
            pre_reg  <= 6'h00;
            tick     <= 1'b0;
        end else begin
            insn_reg <= insn_reg + 2'h1;
            tick     <= 1'b0;
            if (clr) begin
                pre_reg <= 6'h00;
            end else if (insn_tick) begin
                if (pre_reg >= pre_tc) begin
                    pre_reg <= 6'h00;
                    tick    <= 1'b1;
                end else begin
                    pre_reg <= pre_reg + 6'h01;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: design/pwm_time_base.v */
/*
 * PWM time base: 15-bit up or up/down counter with prescaler, postscaler,
 * double-buffered period and one level interrupt.
 * Assumes a register port with one-cycle strobes and read data one cycle later.
 */
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "pwm_time_base_map.vh"
`default_nettype none

module pwm_time_base #(
    parameter CNT_W = 15  // Counter width
) (
    input  wire        clk,        // Oscillator clock, 50 MHz
    input  wire        rstn,       // Synchronous reset, active low
    input  wire [3:0]  addr,       // Register word address
    input  wire [15:0] wdata,      // Write data
    input  wire        wr,         // Write strobe
    input  wire        rd,         // Read strobe
    output reg  [15:0] rdata,      // Read data, cycle after rd
    output reg         irq,        // Level interrupt
    output reg  [14:0] count_out,  // Counter value to comparators
    output reg         dir_out     // Count direction, 1 while down
);

    reg  [15:0]      control_reg;
    reg  [CNT_W-1:0] count_reg;
    reg              down_reg;
    reg  [CNT_W-1:0] period_buf_reg;
    reg  [CNT_W-1:0] period_reg;
    reg  [3:0]       post_reg;
    reg              status_reg;
    reg              mask_reg;

    wire             enable;
    wire [1:0]       mode;
    wire [1:0]       pre_sel;
    wire [3:0]       post_sel;
    wire             tick;
    wire             wr_ctl;
    wire             wr_cnt;
    wire             scale_clr;
    wire             match;
    wire             at_zero;
    wire             period_zero;
    wire             run;
    wire             updown;

    reg              raw_post_ev;
    reg              raw_direct_ev;
    reg              event_now;
    reg  [3:0]       post_next;

    // Compare of count against a period value
    function cnt_match;
        input [CNT_W-1:0] a;
        input [CNT_W-1:0] b;
        begin
            cnt_match = (a == b);
        end
    endfunction

    assign enable      = control_reg[`CTL_ENABLE_BIT];
    assign mode        = control_reg[`CTL_MODE_MSB:`CTL_MODE_LSB];
    assign pre_sel     = control_reg[`CTL_PRE_MSB:`CTL_PRE_LSB];
    assign post_sel    = control_reg[`CTL_POST_MSB:`CTL_POST_LSB];
    assign wr_ctl      = wr && (addr == `ADDR_CONTROL);
    assign wr_cnt      = wr && (addr == `ADDR_COUNT);
    assign scale_clr   = wr_ctl || wr_cnt;
    assign match       = cnt_match(count_reg, period_reg);
    assign at_zero     = cnt_match(count_reg, {CNT_W{1'b0}});
    assign period_zero = cnt_match(period_reg, {CNT_W{1'b0}});
    assign run         = enable && tick && !period_zero;
    assign updown      = mode[1];

    // Prescaled counting tick
    tb_tick_gen u_tick (
        .clk     (clk),
        .rstn    (rstn),
        .clr     (scale_clr),
        .pre_sel (pre_sel),
        .tick    (tick)
    );

    // Classify this tick's events by mode
    always @* begin
        raw_post_ev   = 1'b0;
        raw_direct_ev = 1'b0;
        if (run) begin
            case (mode)
                `MODE_FREE: begin
                    raw_post_ev = match;
                end
                `MODE_SINGLE: begin
                    raw_direct_ev = match;
                end
                `MODE_UPDOWN: begin
                    raw_post_ev = down_reg && at_zero;
                end
                default: begin
                    raw_direct_ev = (match && !down_reg) || (at_zero && down_reg);
                end
            endcase
        end
    end

    // Postscaler thins qualifying events
    always @* begin
        post_next = post_reg;
        event_now = raw_direct_ev;
        if (raw_post_ev) begin
            if (post_reg >= post_sel) begin
                post_next = 4'h0;
                event_now = 1'b1;
            end else begin
                post_next = post_reg + 4'h1;
            end
        end
    end

    // Postscale counter
    always @(posedge clk) begin
        if (!rstn) begin
            post_reg <= 4'h0;
        end else if (scale_clr) begin
            post_reg <= 4'h0;
        end else begin
            post_reg <= post_next;
        end
    end

    // Control register; single shot clears enable in hardware
    always @(posedge clk) begin
        if (!rstn) begin
            control_reg <= `RST_CONTROL;
        end else if (wr_ctl) begin
            control_reg <= wdata;
        end else if (run && match && (mode == `MODE_SINGLE)) begin
            control_reg[`CTL_ENABLE_BIT] <= 1'b0;
        end
    end

    // Counter and direction
    always @(posedge clk) begin
        if (!rstn) begin
            count_reg <= `RST_COUNT;
            down_reg  <= 1'b0;
        end else if (wr_cnt) begin
            count_reg <= wdata[CNT_W-1:0];
        end else if (run) begin
            if (!updown) begin
                down_reg <= 1'b0;
                if (match) begin
                    count_reg <= {CNT_W{1'b0}};
                end else begin
                    count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end else if (down_reg) begin
                if (at_zero) begin
                    down_reg  <= 1'b0;
                    count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end else begin
                    count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end else if (match) begin
                down_reg  <= 1'b1;
                count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Period buffer and active period
    always @(posedge clk) begin
        if (!rstn) begin
            period_buf_reg <= `RST_PERIOD;
            period_reg     <= `RST_PERIOD;
        end else begin
            if (wr && (addr == `ADDR_PERIOD)) begin
                period_buf_reg <= wdata[CNT_W-1:0];
            end
            if (!enable) begin
                period_reg <= period_buf_reg;
            end else if (!period_zero) begin
                if (!updown && run && match) begin
                    period_reg <= period_buf_reg;
                end else if (updown && at_zero) begin
                    period_reg <= period_buf_reg;
                end
            end
        end
    end

    // Sticky status, write one to clear; set wins
    always @(posedge clk) begin
        if (!rstn) begin
            status_reg <= 1'b0;
            mask_reg   <= `RST_MASK;
        end else begin
            if (event_now) begin
                status_reg <= 1'b1;
            end else if (wr && (addr == `ADDR_IRQ_STATUS) && wdata[`IRQ_TB_BIT]) begin
                status_reg <= 1'b0;
            end
            if (wr && (addr == `ADDR_IRQ_MASK)) begin
                mask_reg <= wdata[`IRQ_TB_BIT];
            end
        end
    end

    // Registered outputs and read data
    always @(posedge clk) begin
        if (!rstn) begin
            rdata     <= 16'h0000;
            irq       <= 1'b0;
            count_out <= 15'h0000;
            dir_out   <= 1'b0;
        end else begin
            irq       <= status_reg && mask_reg;
            count_out <= count_reg;
            dir_out   <= down_reg;
            rdata     <= 16'h0000;
            if (rd) begin
                case (addr)
                    `ADDR_CONTROL:    rdata <= control_reg;
                    `ADDR_COUNT:      rdata <= {down_reg, count_reg};
                    `ADDR_PERIOD:     rdata <= {1'b0, period_buf_reg};
                    `ADDR_IRQ_STATUS: rdata <= {15'h0000, status_reg};
                    `ADDR_IRQ_MASK:   rdata <= {15'h0000, mask_reg};
                    default:          rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: testbench/pwm_time_base_assertions.sv */
/* Port assertions for the PWM time base.
   Assumes one clock and a synchronous active low reset. */
`default_nettype none
module pwm_time_base_checker (
    input wire logic        clk,        // Clock
    input wire logic        rstn,       // Reset, low
    input wire logic        wr,         // Write strobe
    input wire logic        rd,         // Read strobe
    input wire logic [15:0] rdata,      // Read data
    input wire logic        irq,        // Interrupt
    input wire logic [14:0] count_out,  // Counter copy
    input wire logic        dir_out     // Direction
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Counter moves without a recent write
    sequence up_s;
        $changed(count_out) && !$past(wr) && !$past(wr, 2) && !dir_out && !$past(dir_out);
    endsequence
    sequence down_s;
        $changed(count_out) && !$past(wr) && !$past(wr, 2) && dir_out && $past(dir_out);
    endsequence
    AST_UP_STEP: assert property (up_s |-> count_out == $past(count_out) + 15'h0001 || count_out == 15'h0000)
        else $error("up count step wrong");
    AST_DOWN_STEP: assert property (down_s |-> count_out == $past(count_out) - 15'h0001)
        else $error("down count step wrong");
    AST_TICK_GAP: assert property ($changed(count_out) && !$past(wr, 2)
        |=> ($stable(count_out) || $past(wr, 2))[*3])
        else $error("ticks closer than four cycles");
    AST_TOP_TURN: assert property ($rose(dir_out) |-> count_out != 15'h0000)
        else $error("turned down at zero");
    AST_ZERO_TURN: assert property ($fell(dir_out) |-> count_out <= 15'h0001)
        else $error("turned up away from zero");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read cycle");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("interrupt dropped without a write");
    AST_RST_OUT: assert property ($rose(rstn) |-> count_out == 15'h0000 && !dir_out && !irq)
        else $error("outputs not clear after reset");
endmodule
bind pwm_time_base pwm_time_base_checker u_chk (.clk(clk), .rstn(rstn), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .count_out(count_out), .dir_out(dir_out));
`default_nettype wire

/* File: testbench/testbench.sv */
/* Self-checking bench for the PWM time base.
   Assumes the design and its checker are compiled first. */
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;        // Clock
    logic        rstn = 1'b0;       // Reset, low
    logic [3:0]  addr = 4'h0;       // Address
    logic [15:0] wdata = 16'h0000;  // Write data
    logic        wr = 1'b0;         // Write strobe
    logic        rd = 1'b0;         // Read strobe
    wire  [15:0] rdata;             // Read data
    wire         irq;               // Interrupt
    wire  [14:0] count_out;         // Counter
    wire         dir_out;           // Direction
    logic [15:0] d;                 // Last read
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          c, n, p, m, dir, cyc, i, k, ev;
    pwm_time_base u_pwm_time_base (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .count_out(count_out), .dir_out(dir_out));
    // Clock and hang guard
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            conclude();
        end
    end
    // Register bus cycles
    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Waits on the counter, bounded
    task automatic nxt;
        logic [14:0] v;
        #1 v = count_out;
        cyc = 0;
        while (count_out === v && cyc < 3000) begin
            @(posedge clk);
            #1 cyc++;
        end
    endtask
    task automatic till(input logic [14:0] v);
        cyc = 0;
        #1;
        while (count_out !== v && cyc < 3000) begin
            @(posedge clk);
            #1 cyc++;
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'hdbfee6e8));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, unmapped address included
        for (i = 0; i < 6; i++) begin
            rreg(i[3:0]);
            `CHK("reset", 16'h0000, d)
        end
        // Tick spacing for each prescale code
        wreg(4'h2, 16'h0064);
        for (p = 0; p < 4; p++) begin
            wreg(4'h1, 16'h0000);
            wreg(4'h0, 16'(32'h8000 | (p << 2)));
            nxt();
            nxt();
            `CHK("tick", 4 << (2 * p), cyc)
            wreg(4'h0, 16'h0000);
        end
        // Counter against the model, free running then up/down
        for (m = 0; m < 3; m += 2) begin
            p = 2 + $urandom % 4;  // Period of one avoided
            wreg(4'h2, 16'(p));
            wreg(4'h1, 16'h0000);
            wreg(4'h3, 16'h0001);
            wreg(4'h0, 16'(32'h8000 | m));
            c = 0;
            dir = 0;
            ev = 0;
            for (k = 0; k < 2 * p + 1; k++) begin
                if ((dir == 1 && c == 0) || (m == 0 && c == p)) ev = 1;
                if (dir == 1 && c == 0) dir = 0;
                else if (m == 2 && c == p) dir = 1;
                if (m == 0 && c == p) c = 0;
                else c = dir ? c - 1 : c + 1;
                nxt();
                `CHK("count", 15'(c), count_out)
                `CHK("dir", dir[0], dir_out)
                rreg(4'h3);
                `CHK("event", ev[0], d[0])
            end
            rreg(4'h1);
            `CHK("dir bit", 1'b0, d[15])
            wreg(4'h0, 16'h0000);
            rreg(4'h1);
            c = d;
            repeat (40) @(posedge clk);
            rreg(4'h1);
            `CHK("hold", 16'(c), d)
        end
        // Postscaled events and the interrupt line
        n = $urandom % 4;
        wreg(4'h2, 16'h0002);
        wreg(4'h4, 16'h0001);
        wreg(4'h3, 16'h0001);
        wreg(4'h1, 16'h0000);
        wreg(4'h0, 16'(32'h8000 | (n << 4)));
        for (k = 0; k <= n; k++) begin
            till(15'h0002);
            till(15'h0000);
            settle();
            rreg(4'h3);
            `CHK("post", 1'(k == n), d[0])
        end
        wreg(4'h0, 16'h0000);
        settle();
        `CHK("irq on", 1'b1, irq)
        wreg(4'h4, 16'h0000);
        settle();
        `CHK("irq masked", 1'b0, irq)
        wreg(4'h4, 16'h0001);
        wreg(4'h3, 16'h0001);
        settle();
        `CHK("irq cleared", 1'b0, irq)
        // Single shot stops itself, postscaler ignored
        wreg(4'h2, 16'h0003);
        wreg(4'h1, 16'h0000);
        wreg(4'h0, 16'h8031);
        till(15'h0003);
        till(15'h0000);
        settle();
        rreg(4'h0);
        `CHK("single en", 1'b0, d[15])
        rreg(4'h3);
        `CHK("single ev", 1'b1, d[0])
        settle();
        `CHK("single stop", 15'h0000, count_out)
        // Double update events at match and at zero
        wreg(4'h1, 16'h0000);
        wreg(4'h0, 16'h8033);
        till(15'h0001);
        for (k = 0; k < 2; k++) begin
            wreg(4'h3, 16'h0001);
            till(k ? 15'h0000 : 15'h0003);
            settle();
            rreg(4'h3);
            `CHK("double ev", 1'b1, d[0])
        end
        // Zero period stops and blocks reload while enabled
        wreg(4'h0, 16'h0000);
        wreg(4'h2, 16'h0000);
        wreg(4'h1, 16'h0000);
        wreg(4'h3, 16'h0001);
        wreg(4'h0, 16'h8000);
        wreg(4'h2, 16'h0005);
        repeat (60) @(posedge clk);
        #1 `CHK("zero stop", 15'h0000, count_out)
        rreg(4'h3);
        `CHK("zero ev", 1'b0, d[0])
        wreg(4'h0, 16'h0000);
        wreg(4'h0, 16'h8000);
        till(15'h0005);
        `CHK("reload", 1'b1, 1'(cyc < 100))
        // Count write clears the prescaler
        wreg(4'h0, 16'h0000);
        wreg(4'h2, 16'h0064);
        wreg(4'h1, 16'h0000);
        wreg(4'h0, 16'h800C);
        repeat (200) @(posedge clk);
        wreg(4'h1, 16'h000A);
        nxt();
        nxt();
        `CHK("pre clear", 1'b1, 1'(cyc > 250 && cyc < 262))
        // Second reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rreg(4'h0);
        `CHK("reset ctl", 16'h0000, d)
        conclude();
    end
endmodule
`default_nettype wire
